// File: core/aps_alarm_regs.vh
// alarm pin setup constants: register address, field positions, reset value
// assumes a 7-bit register address carried by the serial control front end
`ifndef APS_ALARM_REGS_VH
`define APS_ALARM_REGS_VH

`define APS_ADDR_SETUP      7'h06
`define APS_ADDR_STAT_A     7'h43
`define APS_ADDR_STAT_B     7'h44
`define APS_SETUP_RESET     16'h0000
`define APS_SETUP_WMASK     16'hFFC0
`define APS_BIT_TMP_LATCH   15
`define APS_BIT_TMP_MASK    14
`define APS_BIT_SK_LATCH    13
`define APS_BIT_SK_MASK     12
`define APS_BIT_GS_LATCH    11
`define APS_BIT_GS_MASK     10
`define APS_BIT_CL_LATCH    9
`define APS_BIT_CL_MASK     8
`define APS_BIT_GD_LATCH    7
`define APS_BIT_GD_MASK     6

`endif

// File: core/aps_alarm_setup.v
// alarm pin setup logic: setup register, latching, masking, shared kelvin pin
// assumes a serial front end presents decoded register writes and reads on clk
// assumes the three alarm pins are open drain with pull-ups on the board
//
// Functional notes
// - setup bit 15 chooses latched or live signalling on the temperature alarm pin.
// - setup bit 14 keeps the temperature alarm pin from signalling.
// - setup bit 13 chooses latched or live form of the sense kelvin alarm on the shared pin.
// - setup bit 12 removes the sense kelvin alarm from the shared pin.
// - guard, ground sense and sense kelvin alarms are ored onto one open-drain pin, each only when unmasked.
// - setup bit 11 chooses latched or live form of the ground sense alarm on the shared pin.
// - setup bit 10 removes the ground sense alarm from the shared pin.
// - the ground sense mask also turns off the pull-up on the ground sense input.
// - setup bit 9 chooses latched or live signalling on the clamp alarm pin.
// - setup bit 8 keeps the clamp alarm pin from signalling.
// - setup bit 7 chooses latched or live form of the guard alarm on the shared pin.
// - setup bit 6 removes the guard alarm from the shared pin.
// - masked alarms still show in both alarm status registers.
`timescale 1ns/1ps
`include "aps_alarm_regs.vh"
module aps_alarm_setup #(
    parameter ADDR_W = 7,
    parameter NSRC = 5
) (
    // clock and reset
    input wire clk,
    input wire rst,
    input wire clk_en,
    // register access from the serial front end
    input wire reg_wr,
    input wire reg_rd,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    // host clear of held alarms, one bit per source
    input wire [NSRC-1:0] alarm_clear,
    // alarm conditions: temperature, sense kelvin, ground sense, clamp, guard
    input wire temp_cond,
    input wire sense_kelvin_cond,
    input wire ground_sense_cond,
    input wire clamp_cond,
    input wire guard_cond,
    // open-drain pins, enable low while pulling the pin low
    output wire temperature_alarm_pin_o,
    output reg temperature_alarm_pin_oe_n,
    output wire clamp_alarm_pin_o,
    output reg clamp_alarm_pin_oe_n,
    output wire kelvin_shared_alarm_pin_o,
    output reg kelvin_shared_alarm_pin_oe_n,
    // ground sense input pull-up enable
    output reg ground_pullup_en,
    // setup register contents
    output reg [15:0] alarm_pin_setup
);
    // ----------------------------------------
    // register decode
    // ----------------------------------------
    // a strobe only counts on an enabled edge, so a frozen block ignores the host
    wire wr_take;
    wire rd_take;
    wire hit_setup;
    wire hit_stat_live;
    wire hit_stat_held;
    assign wr_take = clk_en & reg_wr;
    assign rd_take = clk_en & reg_rd;
    assign hit_setup = (reg_addr == `APS_ADDR_SETUP);
    assign hit_stat_live = (reg_addr == `APS_ADDR_STAT_A);
    assign hit_stat_held = (reg_addr == `APS_ADDR_STAT_B);

    // ----------------------------------------
    // setup register
    // ----------------------------------------
    // low bits are stored as zero whatever the host sends
    reg [15:0] next_setup;
    always @* begin
        next_setup = alarm_pin_setup;
        if (wr_take && hit_setup) begin
            next_setup = reg_wdata & `APS_SETUP_WMASK;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alarm_pin_setup <= `APS_SETUP_RESET;
        end else begin
            alarm_pin_setup <= next_setup;
        end
    end

    // ----------------------------------------
    // per-source latching
    // ----------------------------------------
    wire [NSRC-1:0] cond_vec;
    wire [NSRC-1:0] latch_vec;
    wire [NSRC-1:0] mask_vec;
    wire [NSRC-1:0] active_vec;
    wire [NSRC-1:0] held_vec;
    assign cond_vec = {guard_cond, clamp_cond, ground_sense_cond, sense_kelvin_cond, temp_cond};
    assign latch_vec = {alarm_pin_setup[`APS_BIT_GD_LATCH],
                        alarm_pin_setup[`APS_BIT_CL_LATCH],
                        alarm_pin_setup[`APS_BIT_GS_LATCH],
                        alarm_pin_setup[`APS_BIT_SK_LATCH],
                        alarm_pin_setup[`APS_BIT_TMP_LATCH]};
    assign mask_vec = {alarm_pin_setup[`APS_BIT_GD_MASK],
                       alarm_pin_setup[`APS_BIT_CL_MASK],
                       alarm_pin_setup[`APS_BIT_GS_MASK],
                       alarm_pin_setup[`APS_BIT_SK_MASK],
                       alarm_pin_setup[`APS_BIT_TMP_MASK]};

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
            aps_alarm_src u_src (
                .clk(clk),
                .rst(rst),
                .clk_en(clk_en),
                .latch_mode(latch_vec[gi]),
                .clear(alarm_clear[gi]),
                .cond(cond_vec[gi]),
                .active(active_vec[gi]),
                .held(held_vec[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    // pins registered so they cannot glitch on a setup write
    wire [NSRC-1:0] flag_vec;
    wire temp_flag;
    wire sk_flag;
    wire gs_flag;
    wire clamp_flag;
    wire guard_flag;
    wire kelvin_flag;
    assign flag_vec = active_vec & ~mask_vec;
    assign temp_flag = flag_vec[0];
    assign sk_flag = flag_vec[1];
    assign gs_flag = flag_vec[2];
    assign clamp_flag = flag_vec[3];
    assign guard_flag = flag_vec[4];
    // one pin for three sources: software reads status to tell them apart
    assign kelvin_flag = sk_flag | gs_flag | guard_flag;

    // open drain: the data side stays low and only the enable moves
    assign temperature_alarm_pin_o = 1'b0;
    assign clamp_alarm_pin_o = 1'b0;
    assign kelvin_shared_alarm_pin_o = 1'b0;

    // a setup write reaches the pins one edge after it lands
    reg next_temp_oe_n;
    reg next_clamp_oe_n;
    reg next_kelvin_oe_n;
    reg next_pullup_en;
    always @* begin
        next_temp_oe_n = temperature_alarm_pin_oe_n;
        next_clamp_oe_n = clamp_alarm_pin_oe_n;
        next_kelvin_oe_n = kelvin_shared_alarm_pin_oe_n;
        next_pullup_en = ground_pullup_en;
        if (clk_en) begin
            next_temp_oe_n = ~temp_flag;
            next_clamp_oe_n = ~clamp_flag;
            next_kelvin_oe_n = ~kelvin_flag;
            // pull-up off while masked, so an unwatched ground line draws no current
            next_pullup_en = ~alarm_pin_setup[`APS_BIT_GS_MASK];
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            temperature_alarm_pin_oe_n <= 1'b1;
            clamp_alarm_pin_oe_n <= 1'b1;
            kelvin_shared_alarm_pin_oe_n <= 1'b1;
            ground_pullup_en <= 1'b1;
        end else begin
            temperature_alarm_pin_oe_n <= next_temp_oe_n;
            clamp_alarm_pin_oe_n <= next_clamp_oe_n;
            kelvin_shared_alarm_pin_oe_n <= next_kelvin_oe_n;
            ground_pullup_en <= next_pullup_en;
        end
    end

    // ----------------------------------------
    // status words
    // ----------------------------------------
    // status ignores the masks so software still sees masked alarms
    wire [15:0] stat_live;
    wire [15:0] stat_held;
    assign stat_live = {{(16-NSRC){1'b0}}, cond_vec};
    assign stat_held = {{(16-NSRC){1'b0}}, held_vec};

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // reads have no side effect, so status can be polled freely
    reg [15:0] next_rdata;
    always @* begin
        next_rdata = reg_rdata;
        if (rd_take) begin
            if (hit_setup) begin
                next_rdata = alarm_pin_setup;
            end else if (hit_stat_live) begin
                next_rdata = stat_live;
            end else if (hit_stat_held) begin
                next_rdata = stat_held;
            end else begin
                // unmapped reads answer zero rather than stale data
                next_rdata = 16'h0000;
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end
endmodule

// File: core/aps_alarm_src.v
// one alarm source: optional latch, live and held status
// assumes condition and clear are synchronous to clk
`timescale 1ns/1ps
module aps_alarm_src (
    // clock and reset
    input wire clk,
    input wire rst,
    input wire clk_en,
    // control
    input wire latch_mode,
    input wire clear,
    // condition
    input wire cond,
    // result
    output wire active,
    output reg held
);
    // set wins over clear so no event is lost
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= 1'b0;
        end else if (clk_en) begin
            if (cond)
                held <= 1'b1;
            else if (clear)
                held <= 1'b0;
        end
    end
    // unlatched tracks the live condition
    assign active = latch_mode ? (held | cond) : cond;
endmodule

// File: tb/alarm_pin_setup_logic_bench.sv
// bench: setup register access, per-source masking, latching and clearing
// assumes the pull-up model and the bound checker
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module alarm_pin_setup_logic_bench;
    logic clk = 0, rst = 1, wr = 0, rd = 0, en = 1;
    logic [6:0] ad = 0;
    logic [15:0] wd = 0;
    logic [4:0] c = 0, clr = 0;
    wire [15:0] rdat, st;
    wire [2:0] o, oe_n, p;
    wire pu;
    int miscompares = 0, cmp_count = 0, cyc = 0;
    logic [2:0] pm [5] = '{3'h1, 3'h4, 3'h4, 3'h2, 3'h4};
    logic [15:0] mb [5] = '{16'h4000, 16'h1000, 16'h0400, 16'h0100, 16'h0040};
    aps_alarm_setup u_dut(.clk(clk), .rst(rst), .clk_en(en), .reg_wr(wr), .reg_rd(rd), .reg_addr(ad),
        .reg_wdata(wd), .reg_rdata(rdat), .alarm_clear(clr), .temp_cond(c[0]), .sense_kelvin_cond(c[1]),
        .ground_sense_cond(c[2]), .clamp_cond(c[3]), .guard_cond(c[4]), .temperature_alarm_pin_o(o[0]),
        .temperature_alarm_pin_oe_n(oe_n[0]), .clamp_alarm_pin_o(o[1]), .clamp_alarm_pin_oe_n(oe_n[1]),
        .kelvin_shared_alarm_pin_o(o[2]), .kelvin_shared_alarm_pin_oe_n(oe_n[2]), .ground_pullup_en(pu),
        .alarm_pin_setup(st));
    aps_pin_pull u_pull(.o(o), .oe_n(oe_n), .lvl(p));
    initial forever #5 clk = ~clk;
    // the run needs about 72 cycles
    always @(posedge clk) if (++cyc > 400) begin
        miscompares++;
        stop_test;
    end
    task automatic wr_reg(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk) {wr, ad, wd} = {1'h1, a, d};
        @(negedge clk) wr = 0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] e);
        @(negedge clk) {rd, ad} = {1'h1, a};
        @(negedge clk) rd = 0;
        `CHK(rdat, e)
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        `CHK({pu, p}, 4'hF)
        rd_chk(7'h06, 16'h0000);
        rd_chk(7'h10, 16'h0000);
        $display("reset test done");
        // one source unmasked at a time, every condition high
        for (int i = 0; i < 5; i++) begin
            wr_reg(7'h06, 16'h5540 ^ mb[i]);
            c = 5'h1F;
            repeat (2) @(negedge clk);
            `CHK(p, ~pm[i])
            `CHK(pu, 1'(i == 2))
            rd_chk(7'h43, 16'h001F);
            c = 0;
            repeat (2) @(negedge clk);
            `CHK(p, 3'h7)
        end
        rd_chk(7'h44, 16'h001F);
        $display("mask test done");
        wr_reg(7'h06, 16'hAA80);
        clr = 5'h1F;
        @(negedge clk) {clr, c} = 10'h01F;
        @(negedge clk) c = 0;
        repeat (2) @(negedge clk);
        `CHK({pu, p}, 4'h8)
        clr = 5'h1F;
        repeat (3) @(negedge clk);
        `CHK(p, 3'h7)
        clr = 0;
        `CHK(st, 16'hAA80)
        $display("latch test done");
        // frozen clock enable: conditions and a write must leave no trace
        en = 0;
        c = 5'h1F;
        wr_reg(7'h06, 16'h5540);
        `CHK(p, 3'h7)
        c = 0;
        @(negedge clk) en = 1;
        repeat (2) @(negedge clk);
        `CHK(p, 3'h7)
        rd_chk(7'h06, 16'hAA80);
        $display("freeze test done");
        // set beats clear in one cycle, then one source cleared alone
        @(negedge clk) {clr, c} = 10'h3FF;
        @(negedge clk) {clr, c} = 10'h000;
        rd_chk(7'h44, 16'h001F);
        @(negedge clk) clr = 5'h02;
        @(negedge clk) clr = 0;
        rd_chk(7'h44, 16'h001D);
        `CHK(p, 3'h0)
        $display("clear test done");
        stop_test;
    end
endmodule

// File: tb/aps_alarm_chk_assertions.sv
// checker: pin masking, live signalling and pull-up control
// skips any edge that follows a frozen clock-enable edge; bound into the setup top
`timescale 1ns/1ps
module aps_alarm_chk (
    // clock, reset and sources
    input wire clk,
    input wire rst,
    input wire clk_en,
    input wire temp_cond,
    input wire sense_kelvin_cond,
    input wire ground_sense_cond,
    input wire clamp_cond,
    input wire guard_cond,
    // pins and setup
    input wire temperature_alarm_pin_oe_n,
    input wire clamp_alarm_pin_oe_n,
    input wire kelvin_shared_alarm_pin_oe_n,
    input wire ground_pullup_en,
    input wire [15:0] alarm_pin_setup
);
    wire [15:0] s = alarm_pin_setup;
    wire t_n = temperature_alarm_pin_oe_n;
    wire c_n = clamp_alarm_pin_oe_n;
    wire k_n = kelvin_shared_alarm_pin_oe_n;
    wire k_on = (guard_cond & !s[6]) | (sense_kelvin_cond & !s[12]) | (ground_sense_cond & !s[10]);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_tmp_masked: assert property ($past(clk_en & s[14]) |-> t_n) else $error("tmp masked");
    a_tmp_live: assert property ($past(clk_en & temp_cond & !s[14]) |-> !t_n) else $error("tmp missed");
    a_tmp_unlatched: assert property ($past(clk_en & !temp_cond & !s[15]) |-> t_n) else $error("tmp stuck");
    a_clamp_masked: assert property ($past(clk_en & s[8]) |-> c_n) else $error("clamp masked");
    a_clamp_live: assert property ($past(clk_en & clamp_cond & !s[8]) |-> !c_n) else $error("clamp missed");
    a_kel_masked: assert property ($past(clk_en & s[12] & s[10] & s[6]) |-> k_n) else $error("kel masked");
    a_kel_shared: assert property ($past(clk_en & k_on) |-> !k_n) else $error("kel missed");
    a_pullup_off: assert property ($past(clk_en) |-> ground_pullup_en == !$past(s[10])) else $error("pullup");
    c_tmp_held: cover property (s[15] && !t_n && !temp_cond);
    c_kel_shared: cover property (!k_n && s[12]);
    c_pullup_off: cover property (!ground_pullup_en);
endmodule
bind aps_alarm_setup aps_alarm_chk u_chk(.*);

// File: tb/aps_pin_pull.sv
// partner: board pull-ups on the three open-drain alarm pins
// assumes the device only sinks current
`timescale 1ns/1ps
module aps_pin_pull (
    // device side and wire level
    input wire [2:0] o,
    input wire [2:0] oe_n,
    output wire [2:0] lvl
);
    // a released pin floats high; an unknown enable stays unknown
    assign lvl = oe_n | (~oe_n & o);
endmodule
